// file: dv/cfsc_host.sv
// Purpose: Host model that drives the register port.
// Assumes: Each call starts just after a rising edge.
// Notes:   Strobes stay up until idle, so back to back is clean.
module cfsc_host (
  // Bus.
  input  wire logic        i_clk,
  output logic      [7:0]  o_addr,
  output logic      [19:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [19:0] d);
    logic [19:0] v;
    v = d;
    if (a == cfsc_pkg::OFF_AUTOCAL)
      v[3:2] = 2'h1;
    o_wr    <= w && (a < 8'h23 || (a >= 8'h40 && a < 8'h70));
    o_rd    <= !w;
    o_addr  <= a;
    o_wdata <= v;
    @(posedge i_clk);
  endtask
  task automatic idle();
    o_wr <= 1'h0;
    o_rd <= 1'h0;
    @(posedge i_clk);
  endtask
endmodule

// file: dv/tb_channel_filter_serial_cal_regs.sv
// Purpose: Self-checking bench for the channel filter register bank.
// Assumes: A short calibration wait keeps the run brief.
// Notes:   Pin sync and soft sync both drive the same clear path.
module tb_channel_filter_serial_cal_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr, rd, rd_d = 0, fov = 0;
  logic [3:0] pul = '0;
  logic [1:0] sel = '0;
  logic [7:0] addr;
  logic [19:0] wdata, rdata, cd;
  logic [5:0] acb;
  logic [2:0] aph;
  logic iclr, cv, cl, tick, fs, cs, pd;
  logic pin = 0, ste;
  logic [23:0] stv;
  cfsc_pkg::cfsc_filter_t fcfg;
  cfsc_pkg::cfsc_serial_t scfg;
  logic [20:0] rq[$], cq[$];
  logic [19:0] mem[48];
  logic [7:0] offs[9] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h21};
  logic [19:0] msk[9] = '{20'h7, 20'h7, 20'h3F, 20'h3F, 20'h3, 20'hFF, 20'hFF, 20'hFF, 20'h1FF};
  int err_total = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  cfsc_host host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  cfsc_regs #(.CAL_WAIT_CYCLES(4)) dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_pin_sync(pin), .i_soft_sync(pul[0]),
    .i_filter_start(pul[1]), .o_iir_clear(iclr), .o_filter_cfg(fcfg),
    .o_active_phase(aph), .o_active_coef_base(acb), .o_coef_data(cd),
    .o_coef_valid(cv), .o_coef_last(cl), .i_word_start(pul[2]), .i_word_sel(sel),
    .i_first_out_valid(fov), .o_serial_cfg(scfg), .o_sclk_tick(tick),
    .o_frame_sync(fs), .o_self_test_value(stv), .o_self_test_enable(ste),
    .i_cal_done(pul[3]), .o_cal_start(cs), .o_analog_powerdown(pd));
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("counts: %0d compared, %0d wrong", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [19:0] e);
    rq.push_back({1'h0, e});
    host.acc(1'h0, a, 20'h0);
  endtask
  task automatic pulse(input int b);
    pul[b] <= 1'h1;
    @(posedge clk);
    pul <= '0;
    @(posedge clk);
  endtask
  // Results are judged from queued notes so the driver never waits on them.
  always @(posedge clk)
  begin
    if (rd_d && rq.size() > 0)
      chk({1'h0, rdata}, rq.pop_front());
    if (cv)
      chk({cl, cd}, cq.size() > 0 ? cq.pop_front() : 21'h1FFFFF);
    rd_d <= rd;
  end
  initial
  begin
    #50us;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(21));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (offs[i]) rdx(offs[i], 20'h0);
    rdx(8'h22, 20'h4);
    rdx(8'h30, 20'h0);
    foreach (offs[i])
    begin
      n = $urandom;
      host.acc(1'h1, offs[i], n[19:0]);
      rdx(offs[i], n[19:0] & msk[i]);
    end
    for (int k = 0; k < 48; k++)
    begin
      n = $urandom;
      mem[k] = n[19:0];
      host.acc(1'h1, 8'h40 + 8'(k), mem[k]);
    end
    rdx(8'h6F, mem[47]);
    $display("done: registers");
    host.acc(1'h1, 8'h18, 20'h5);
    host.acc(1'h1, 8'h1C, 20'h2);
    host.acc(1'h1, 8'h1D, 20'h96);
    host.acc(1'h1, 8'h1E, 20'h5A);
    host.acc(1'h1, 8'h1F, 20'hC3);
    host.acc(1'h1, 8'h20, 20'h1);
    host.acc(1'h1, 8'h1A, 20'h2E);
    host.acc(1'h1, 8'h1B, 20'h3);
    host.acc(1'h1, 8'h19, 20'h5);
    host.idle();
    for (int k = 0; k < 4; k++)
      cq.push_back({k == 3, mem[(46 + k) % 48]});
    pulse(1);
    repeat (5) @(posedge clk);
    chk(21'(acb), 21'h2E);
    chk(21'(aph), 21'h5);
    chk(21'(cq.size()), 21'h0);
    chk(21'(fcfg), 21'h2C);
    chk(21'(stv[23:12]), 21'hC35);
    chk(21'({ste, stv[11:0]}), 21'h1A96);
    for (int m = 0; m < 2; m++)
    begin
      host.acc(1'h1, 8'h17, 20'(m));
      host.idle();
      pulse(0);
      chk(21'(iclr), 21'(m));
      pin <= 1'h1;
      repeat (4) @(posedge clk);
      chk(21'(iclr), 21'(m));
      pin <= 1'h0;
    end
    $display("done: filter and sync");
    host.acc(1'h1, 8'h21, 20'h198);
    host.idle();
    @(posedge clk);
    chk(21'(scfg), 21'h198);
    host.acc(1'h1, 8'h21, 20'h00B);
    host.idle();
    repeat (3) @(posedge clk);
    n = 0;
    repeat (80) @(posedge clk) n += tick;
    chk(21'(n), 21'h14);
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 4; s++)
      begin
        host.acc(1'h1, 8'h21, 20'h8 | 20'(m << 5));
        host.idle();
        sel <= 2'(s);
        fov <= (m == 3);
        pulse(2);
        chk(21'(fs), 21'(m >= 2 || s == 0 || (m == 1 && s == 2)));
      end
    fov <= 1'h0;
    $display("done: serial port");
    host.acc(1'h1, 8'h22, 20'h1);
    host.idle();
    pulse(0);
    n = 0;
    while (cs !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(21'(cs), 21'h1);
    chk(21'(pd), 21'h1);
    pulse(3);
    @(posedge clk);
    chk(21'(pd), 21'h0);
    $display("done: calibration");
    tally_and_finish();
  end
endmodule

// file: rtl/cfsc_pkg.sv
// Purpose: Shared constants and carrier types for the channel filter register bank.
// Assumes: 100 MHz device clock, 8-bit register address, 20-bit register data.
// Notes:   Offsets are word indices on the plain register port.
package cfsc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 20;

  // Register offsets.
  localparam logic [7:0] OFF_IIR_MASK    = 8'h17;
  localparam logic [7:0] OFF_DECIM       = 8'h18;
  localparam logic [7:0] OFF_PHASE       = 8'h19;
  localparam logic [7:0] OFF_COEF_BASE   = 8'h1A;
  localparam logic [7:0] OFF_TAPS        = 8'h1B;
  localparam logic [7:0] OFF_SCALE       = 8'h1C;
  localparam logic [7:0] OFF_SELFTEST_0  = 8'h1D;
  localparam logic [7:0] OFF_SELFTEST_1  = 8'h1E;
  localparam logic [7:0] OFF_SELFTEST_2  = 8'h1F;
  localparam logic [7:0] OFF_SELFTEST_EN = 8'h20;
  localparam logic [7:0] OFF_SERIAL      = 8'h21;
  localparam logic [7:0] OFF_AUTOCAL     = 8'h22;
  localparam logic [7:0] OFF_STATUS      = 8'h23;
  localparam logic [7:0] OFF_COEF_FIRST  = 8'h40;
  localparam logic [7:0] OFF_COEF_LAST   = 8'h6F;
  localparam int unsigned COEF_WORDS     = 48;

  // Reset values.
  localparam logic [2:0]  RST_DECIM     = 3'h0;
  localparam logic [2:0]  RST_PHASE     = 3'h0;
  localparam logic [5:0]  RST_COEF_BASE = 6'h00;
  localparam logic [5:0]  RST_TAPS      = 6'h00;
  localparam logic [1:0]  RST_SCALE     = 2'h0;
  localparam logic [23:0] RST_SELFTEST  = 24'h000000;
  localparam logic [8:0]  RST_SERIAL    = 9'h000;
  localparam logic [3:0]  RST_AUTOCAL   = 4'h4;

  // Frame sync modes.
  localparam logic [1:0] FS_A_I_ONLY  = 2'h0;
  localparam logic [1:0] FS_I_WORDS   = 2'h1;
  localparam logic [1:0] FS_ALL_WORDS = 2'h2;
  localparam logic [1:0] FS_LEVEL     = 2'h3;

  // Word identifiers on the serial stream.
  localparam logic [1:0] WORD_CHAN_A_INPHASE    = 2'h0;
  localparam logic [1:0] WORD_CHAN_A_QUADRATURE = 2'h1;
  localparam logic [1:0] WORD_CHAN_B_INPHASE    = 2'h2;
  localparam logic [1:0] WORD_CHAN_B_QUADRATURE = 2'h3;

  // Calibration warm-up time.
  localparam real CAL_WAIT_MS  = 20.63;
  localparam real CLK_MHZ      = 100.0;
  localparam int  CAL_WAIT_CYC = int'(CAL_WAIT_MS * 1000.0 * CLK_MHZ);

  // Serial control layout, bit 8 down to bit 0.
  typedef struct packed {
    logic       dcc_to_self_test;
    logic       chan_b_on_second;
    logic [1:0] fs_mode;
    logic       word_24bit;
    logic       bus_master;
    logic [2:0] sclk_div;
  } cfsc_serial_t;

  // Autocalibration layout, bit 3 down to bit 0.
  typedef struct packed {
    logic rsvd_zero;
    logic rsvd_one;
    logic keep_powered;
    logic enable;
  } cfsc_autocal_t;

  // Coefficient filter settings handed to the arithmetic.
  typedef struct packed {
    logic [2:0] decim_minus_one;
    logic [1:0] scale_steps;
    logic       iir_mask;
  } cfsc_filter_t;

  typedef enum logic [1:0] {
    CFSC_CAL_IDLE = 2'b00,
    CFSC_CAL_WAIT = 2'b01,
    CFSC_CAL_RUN  = 2'b10
  } cfsc_cal_state_t;

endpackage

// file: rtl/cfsc_regs.sv
// Purpose: Configuration register bank, tap sequencer, serial clock, frame sync and autocal.
// Assumes: Single 100 MHz clock; pin sync is asynchronous, all other inputs are local logic.
// Notes:   Filter arithmetic and dc correction live elsewhere and consume these outputs.
//
// Overview of operation
// R1: With the sync mask on, a sync clears the recursive filter data path.
// R2: Decimation register holds factor minus one in three bits, factors one to eight.
// R3: Phase select may change anytime, loads at each filter start, survives sync.
// R4: Coefficient base pointer is shadowed and reloaded at each filter start.
// R5: Tap count holds taps minus one; each output runs exactly that plus one taps.
// R6: Two-bit scale attenuates output from 0 dB to -18 dB in 6 dB steps.
// R7: Four self-test registers carry a 24-bit value exercising both channel paths; the code holds it in three 8-bit registers plus an enable.
// R8: Serial control bit 8 routes fine dc correction output into self-test.
// R9: Serial control bit 7 sends second channel data on the second output.
// R10: Two-bit frame sync mode picks level, all-word, I-word or first-word pulses.
// R11: Serial control bit 4 selects 24-bit words, otherwise 16-bit words.
// R12: Serial control bit 3 makes the device drive serial clock and frame sync.
// R13: Three-bit divider sets serial clock ratio, division up to eight.
// R14: Autocal enabled waits about 20.63 ms after sync, then runs coarse calibration.
// R15: Autocal bit 1 low lets calibration power down amplifier and mixer.
// R16: Host writes reserved autocal bit 3 as zero and bit 2 as one.
// R17: Host never writes reserved ranges around and above the coefficient store.
// R18: Coefficient store holds forty-eight 20-bit words shared by both channels.
// R19: Recursive filter control bit zero disables the sync mask; one enables it.
// R20: Serial clock divides by field plus one; zero passes every clock.
//
// Decided for this implementation: the plain strobed port.
module cfsc_regs #(
  parameter int CAL_WAIT_CYCLES = cfsc_pkg::CAL_WAIT_CYC
) (
  // Clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  // Register port.
  input  wire logic [7:0]             i_addr,
  input  wire logic [19:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [19:0]            o_rdata,
  // Synchronisation sources.
  input  wire logic                   i_pin_sync,
  input  wire logic                   i_soft_sync,
  // Coefficient filter side.
  input  wire logic                   i_filter_start,
  output logic                        o_iir_clear,
  output cfsc_pkg::cfsc_filter_t      o_filter_cfg,
  output logic      [2:0]             o_active_phase,
  output logic      [5:0]             o_active_coef_base,
  output logic      [19:0]            o_coef_data,
  output logic                        o_coef_valid,
  output logic                        o_coef_last,
  // Serial output port side.
  input  wire logic                   i_word_start,
  input  wire logic [1:0]             i_word_sel,
  input  wire logic                   i_first_out_valid,
  output cfsc_pkg::cfsc_serial_t      o_serial_cfg,
  output logic                        o_sclk_tick,
  output logic                        o_frame_sync,
  // Self-test and calibration.
  output logic      [23:0]            o_self_test_value,
  output logic                        o_self_test_enable,
  input  wire logic                   i_cal_done,
  output logic                        o_cal_start,
  output logic                        o_analog_powerdown
);

  logic [2:0]              decim_reg;
  logic [2:0]              phase_reg;
  logic [5:0]              coef_base_reg;
  logic [5:0]              taps_reg;
  logic [1:0]              scale_reg;
  logic [23:0]             self_test_reg;
  logic                    self_test_en_reg;
  logic [8:0]              serial_reg;
  logic [3:0]              autocal_reg;
  logic                    iir_mask_reg;
  logic [19:0]             coef_mem [cfsc_pkg::COEF_WORDS];
  logic                    pin_meta_reg;
  logic                    pin_sync_reg;
  logic                    pin_prev_reg;
  logic [5:0]              tap_reg;
  logic [5:0]              taps_active_reg;
  logic                    busy_reg;
  logic [2:0]              sclk_cnt_reg;
  logic [21:0]             cal_cnt_reg;
  cfsc_pkg::cfsc_cal_state_t cal_state_reg;
  cfsc_pkg::cfsc_cal_state_t cal_state_next;

  // Shared decode of the coefficient window and index.
  function automatic logic in_coef(input logic [7:0] a);
    return (a >= cfsc_pkg::OFF_COEF_FIRST) && (a <= cfsc_pkg::OFF_COEF_LAST);
  endfunction

  function automatic logic [5:0] coef_index(input logic [7:0] a);
    return 6'(a - cfsc_pkg::OFF_COEF_FIRST);
  endfunction

  // Frame sync decode for pulse modes.
  function automatic logic fs_match(input logic [1:0] mode, input logic [1:0] sel);
    case (mode)
      cfsc_pkg::FS_ALL_WORDS: return 1'b1;
      cfsc_pkg::FS_I_WORDS:   return (sel == cfsc_pkg::WORD_CHAN_A_INPHASE) ||
                                     (sel == cfsc_pkg::WORD_CHAN_B_INPHASE);
      default:                return sel == cfsc_pkg::WORD_CHAN_A_INPHASE;
    endcase
  endfunction

  cfsc_pkg::cfsc_serial_t  serial_cfg;
  cfsc_pkg::cfsc_autocal_t autocal_cfg;
  wire logic               wr_coef    = i_wr && in_coef(i_addr);
  wire logic               sync_event = i_soft_sync || (pin_sync_reg && !pin_prev_reg);
  wire logic [5:0]         tap_base   = i_filter_start ? coef_base_reg : o_active_coef_base;
  wire logic [6:0]         walk_sum   = 7'(tap_base) + 7'(i_filter_start ? 6'h00 : tap_reg);
  wire logic [5:0]         walk_idx   = (walk_sum >= 7'(cfsc_pkg::COEF_WORDS)) ?
                                        6'(walk_sum - 7'(cfsc_pkg::COEF_WORDS)) : 6'(walk_sum);
  wire logic               tap_run    = i_filter_start || busy_reg;
  wire logic [5:0]         tap_limit  = i_filter_start ? taps_reg : taps_active_reg;
  wire logic               tap_end    = tap_run && ((i_filter_start ? 6'h00 : tap_reg) == tap_limit);
  wire logic               sclk_wrap  = sclk_cnt_reg >= serial_cfg.sclk_div;
  wire logic               cal_expire = cal_cnt_reg == 22'(CAL_WAIT_CYCLES - 1);
  logic [19:0]             rd_mux;

  assign serial_cfg  = cfsc_pkg::cfsc_serial_t'(serial_reg);
  assign autocal_cfg = cfsc_pkg::cfsc_autocal_t'(autocal_reg);

  // Read multiplexer; narrow registers read zero above their width.
  always_comb
  begin
    rd_mux = 20'h00000;
    if (in_coef(i_addr))
      rd_mux = coef_mem[coef_index(i_addr)];
    else
      case (i_addr)
        cfsc_pkg::OFF_IIR_MASK:    rd_mux = {19'h00000, iir_mask_reg};
        cfsc_pkg::OFF_DECIM:       rd_mux = {17'h00000, decim_reg};
        cfsc_pkg::OFF_PHASE:       rd_mux = {17'h00000, phase_reg};
        cfsc_pkg::OFF_COEF_BASE:   rd_mux = {14'h0000, coef_base_reg};
        cfsc_pkg::OFF_TAPS:        rd_mux = {14'h0000, taps_reg};
        cfsc_pkg::OFF_SCALE:       rd_mux = {18'h00000, scale_reg};
        cfsc_pkg::OFF_SELFTEST_0:  rd_mux = {12'h000, self_test_reg[7:0]};
        cfsc_pkg::OFF_SELFTEST_1:  rd_mux = {12'h000, self_test_reg[15:8]};
        cfsc_pkg::OFF_SELFTEST_2:  rd_mux = {12'h000, self_test_reg[23:16]};
        cfsc_pkg::OFF_SELFTEST_EN: rd_mux = {19'h00000, self_test_en_reg};
        cfsc_pkg::OFF_SERIAL:      rd_mux = {11'h000, serial_reg};
        cfsc_pkg::OFF_AUTOCAL:     rd_mux = {16'h0000, autocal_reg};
        cfsc_pkg::OFF_STATUS:      rd_mux = {14'h0000, cal_state_reg, busy_reg, o_active_phase};
        default:                   rd_mux = 20'h00000;
      endcase
  end

  // Configuration writes. Unmapped and reserved offsets are ignored.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      iir_mask_reg     <= 1'b0;
      decim_reg        <= cfsc_pkg::RST_DECIM;
      phase_reg        <= cfsc_pkg::RST_PHASE;
      coef_base_reg    <= cfsc_pkg::RST_COEF_BASE;
      taps_reg         <= cfsc_pkg::RST_TAPS;
      scale_reg        <= cfsc_pkg::RST_SCALE;
      self_test_reg    <= cfsc_pkg::RST_SELFTEST;
      self_test_en_reg <= 1'b0;
      serial_reg       <= cfsc_pkg::RST_SERIAL;
      autocal_reg      <= cfsc_pkg::RST_AUTOCAL;
    end
    else if (i_wr)
      case (i_addr)
        cfsc_pkg::OFF_IIR_MASK:    iir_mask_reg         <= i_wdata[0];     // R19
        cfsc_pkg::OFF_DECIM:       decim_reg            <= i_wdata[2:0];   // R2
        cfsc_pkg::OFF_PHASE:       phase_reg            <= i_wdata[2:0];
        cfsc_pkg::OFF_COEF_BASE:   coef_base_reg        <= i_wdata[5:0];
        cfsc_pkg::OFF_TAPS:        taps_reg             <= i_wdata[5:0];
        cfsc_pkg::OFF_SCALE:       scale_reg            <= i_wdata[1:0];   // R6
        cfsc_pkg::OFF_SELFTEST_0:  self_test_reg[7:0]   <= i_wdata[7:0];   // R7
        cfsc_pkg::OFF_SELFTEST_1:  self_test_reg[15:8]  <= i_wdata[7:0];   // R7
        cfsc_pkg::OFF_SELFTEST_2:  self_test_reg[23:16] <= i_wdata[7:0];   // R7
        cfsc_pkg::OFF_SELFTEST_EN: self_test_en_reg     <= i_wdata[0];
        cfsc_pkg::OFF_SERIAL:      serial_reg           <= i_wdata[8:0];
        cfsc_pkg::OFF_AUTOCAL:     autocal_reg          <= i_wdata[3:0];   // R16
        default:                   ;
      endcase
  end

  // The store has no reset; software loads it before the first filter start.
  always_ff @(posedge i_clk)
  begin
    if (wr_coef)
      coef_mem[coef_index(i_addr)] <= i_wdata;                            // R18
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_rdata <= 20'h00000;
    else
      o_rdata <= i_rd ? rd_mux : 20'h00000;
  end

  // Pin sync crosses in through two flops before the edge detector.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= i_pin_sync;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Sync clears the recursive path only while the mask is on; phase is not touched.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_iir_clear <= 1'b0;
    else
      o_iir_clear <= sync_event && iir_mask_reg;                          // R1 R19
  end

  // Shadowed settings reload at every start so mid-filter writes wait their turn.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_active_phase     <= cfsc_pkg::RST_PHASE;
      o_active_coef_base <= cfsc_pkg::RST_COEF_BASE;
      taps_active_reg    <= cfsc_pkg::RST_TAPS;
    end
    else if (i_filter_start)
    begin
      o_active_phase     <= phase_reg;                                    // R3
      o_active_coef_base <= coef_base_reg;                                // R4
      taps_active_reg    <= taps_reg;                                     // R5
    end
  end

  // Tap walk: one coefficient per cycle, taps plus one per output.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      tap_reg      <= 6'h00;
      busy_reg     <= 1'b0;
      o_coef_data  <= 20'h00000;
      o_coef_valid <= 1'b0;
      o_coef_last  <= 1'b0;
    end
    else
    begin
      tap_reg      <= (tap_run && !tap_end) ? 6'((i_filter_start ? 6'h00 : tap_reg) + 6'h01)
                                            : 6'h00;                      // R5
      busy_reg     <= tap_run && !tap_end;
      o_coef_data  <= tap_run ? coef_mem[walk_idx] : 20'h00000;           // R4
      o_coef_valid <= tap_run;
      o_coef_last  <= tap_end;                                            // R5
    end
  end

  // Filter settings and serial format are registered copies of software fields.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_filter_cfg       <= '0;
      o_serial_cfg       <= cfsc_pkg::cfsc_serial_t'(cfsc_pkg::RST_SERIAL);
      o_self_test_value  <= cfsc_pkg::RST_SELFTEST;
      o_self_test_enable <= 1'b0;
    end
    else
    begin
      o_filter_cfg       <= '{decim_minus_one: decim_reg, scale_steps: scale_reg,
                              iir_mask: iir_mask_reg};                    // R2 R6
      o_serial_cfg       <= serial_cfg;                                   // R8 R9 R11
      o_self_test_value  <= self_test_reg;                                // R7
      o_self_test_enable <= self_test_en_reg;
    end
  end

  // Serial clock: one tick every divider plus one cycles, only as bus master.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      sclk_cnt_reg <= 3'h0;
      o_sclk_tick  <= 1'b0;
    end
    else
    begin
      sclk_cnt_reg <= (sclk_wrap || !serial_cfg.bus_master) ? 3'h0 : 3'(sclk_cnt_reg + 3'h1);
      o_sclk_tick  <= serial_cfg.bus_master && sclk_wrap;                 // R12 R13 R20
    end
  end

  // Frame sync is driven only as master; level mode follows the first output's valid.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_frame_sync <= 1'b0;
    else if (!serial_cfg.bus_master)
      o_frame_sync <= 1'b0;                                               // R12
    else if (serial_cfg.fs_mode == cfsc_pkg::FS_LEVEL)
      o_frame_sync <= i_first_out_valid;                                  // R10
    else
      o_frame_sync <= i_word_start && fs_match(serial_cfg.fs_mode, i_word_sel); // R10
  end

  // Calibration sequencer. A fresh sync restarts the warm-up wait.
  always_comb
  begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      cfsc_pkg::CFSC_CAL_IDLE:
        if (sync_event && autocal_cfg.enable)
          cal_state_next = cfsc_pkg::CFSC_CAL_WAIT;
      cfsc_pkg::CFSC_CAL_WAIT:
        if (!autocal_cfg.enable)
          cal_state_next = cfsc_pkg::CFSC_CAL_IDLE;
        else if (cal_expire && !sync_event)
          cal_state_next = cfsc_pkg::CFSC_CAL_RUN;                        // R14
      cfsc_pkg::CFSC_CAL_RUN:
        if (i_cal_done)
          cal_state_next = cfsc_pkg::CFSC_CAL_IDLE;
      default:
        cal_state_next = cfsc_pkg::CFSC_CAL_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      cal_state_reg      <= cfsc_pkg::CFSC_CAL_IDLE;
      cal_cnt_reg        <= 22'h000000;
      o_cal_start        <= 1'b0;
      o_analog_powerdown <= 1'b0;
    end
    else
    begin
      cal_state_reg      <= cal_state_next;
      cal_cnt_reg        <= (cal_state_reg == cfsc_pkg::CFSC_CAL_WAIT && !sync_event) ?
                            22'(cal_cnt_reg + 22'h000001) : 22'h000000;   // R14
      o_cal_start        <= cal_state_reg == cfsc_pkg::CFSC_CAL_WAIT &&
                            cal_state_next == cfsc_pkg::CFSC_CAL_RUN;     // R14
      o_analog_powerdown <= cal_state_next == cfsc_pkg::CFSC_CAL_RUN &&
                            !autocal_cfg.keep_powered;                    // R15
    end
  end

  // Helper count of valid taps in the current walk.
  logic [6:0] seen_reg;
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || o_coef_last || i_filter_start)
      seen_reg <= 7'h00;
    else if (o_coef_valid)
      seen_reg <= 7'(seen_reg + 7'h01);
  end

  sequence s_start_idle;
    i_filter_start && !busy_reg;
  endsequence

  sequence s_sclk_div3;
    o_sclk_tick && serial_cfg.bus_master && serial_cfg.sclk_div == 3'h3 && !i_wr;
  endsequence

  a_iir_clear_on: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R1
    sync_event && iir_mask_reg |=> o_iir_clear)
    else $error("sync with mask on did not clear the recursive path");

  a_iir_mask_off: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R19
    o_iir_clear |-> $past(iir_mask_reg))
    else $error("recursive path cleared while the mask was off");

  a_phase_shadow_load: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R3
    i_filter_start |=> o_active_phase == $past(phase_reg))
    else $error("phase not taken at filter start");

  a_base_held_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R4
    busy_reg && !i_filter_start |=> $stable(o_active_coef_base))
    else $error("coefficient base moved during a filter");

  a_tap_count_exact: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R5
    o_coef_last |-> seen_reg == 7'(taps_active_reg))
    else $error("tap walk length differs from taps plus one");

  a_tap_walk_len: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R5
    s_start_idle ##0 (taps_reg == 6'h03) |=> o_coef_valid [*4] ##0 o_coef_last)
    else $error("four-tap walk did not end on its fourth tap");

  a_sclk_ratio: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R13
    s_sclk_div3 ##1 (!i_wr) [*3] |-> !$past(o_sclk_tick) ##1 o_sclk_tick)
    else $error("serial clock tick not every four cycles");

  a_sclk_master_only: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R12
    o_sclk_tick || o_frame_sync |-> $past(serial_cfg.bus_master))
    else $error("serial clock or frame sync driven while not master");

  a_fs_level_mode: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R10
    serial_cfg.bus_master && serial_cfg.fs_mode == cfsc_pkg::FS_LEVEL
      |=> o_frame_sync == $past(i_first_out_valid))
    else $error("frame sync level mode does not follow first output valid");

  a_fs_ai_only: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R10
    serial_cfg.fs_mode == cfsc_pkg::FS_A_I_ONLY && i_word_sel != cfsc_pkg::WORD_CHAN_A_INPHASE
      |=> !o_frame_sync)
    else $error("frame sync pulsed on a word other than channel A in-phase");

  a_cal_wait_full: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R14
    o_cal_start |-> $past(cal_cnt_reg) == 22'(CAL_WAIT_CYCLES - 1))
    else $error("calibration started before the warm-up wait elapsed");

  a_cal_powerdown: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
    o_analog_powerdown |-> cal_state_reg == cfsc_pkg::CFSC_CAL_RUN &&
      !$past(autocal_cfg.keep_powered))
    else $error("analog power-down outside calibration or while kept powered");

endmodule
